/* common/agms_pkg.sv */
// Shared constants for the attitude gain mode supervisor.
// Assumes a 20 MHz system clock and angular rates scaled at 64 LSB per deg/sec.
`default_nettype none

package agms_pkg;

  // ---------------------------------------------------------------------------
  // Timing
  // ---------------------------------------------------------------------------
  localparam int unsigned CLK_HZ = 20000000;
  localparam int unsigned UPDATE_HZ = 200;
  localparam int unsigned UPDATE_DIV = CLK_HZ / UPDATE_HZ;
  localparam int unsigned FREE_LIMIT_S = 60;
  localparam int unsigned FREE_LIMIT_UPD = FREE_LIMIT_S * UPDATE_HZ;
  localparam int unsigned INIT_UPD = 200;
  localparam int unsigned HIGH_UPD = 2000;

  // ---------------------------------------------------------------------------
  // Rate scaling and limits
  // ---------------------------------------------------------------------------
  localparam int unsigned LSB_PER_DPS = 64;
  localparam int unsigned QUIET_DPS = 3;
  localparam logic [16:0] QUIET_LIM = 17'(QUIET_DPS * LSB_PER_DPS);
  localparam int unsigned RATE_MAX_DPS = 300;
  localparam logic [16:0] RATE_MAX_LIM = 17'(RATE_MAX_DPS * LSB_PER_DPS);
  localparam logic [15:0] TURN_RESET = 16'h0280;

  // ---------------------------------------------------------------------------
  // Register map
  // ---------------------------------------------------------------------------
  localparam logic [7:0] CTRL_OFS = 8'h00;
  localparam logic [7:0] TURN_OFS = 8'h04;
  localparam logic [7:0] STAT_OFS = 8'h08;
  localparam logic [7:0] TIMER_OFS = 8'h0c;
  localparam int unsigned CTRL_FREE_BIT = 0;
  localparam int unsigned CTRL_RESTART_BIT = 1;
  localparam int unsigned CTRL_DYN_BIT = 2;
  localparam logic CTRL_FREE_RESET = 1'b0;
  localparam logic CTRL_RESTART_RESET = 1'b0;
  localparam logic CTRL_DYN_RESET = 1'b1;
  localparam int unsigned STAT_STATE_LSB = 16;

  // ---------------------------------------------------------------------------
  // Built-in-test word layout
  // ---------------------------------------------------------------------------
  localparam int unsigned BIT_FATAL = 0;
  localparam int unsigned BIT_ALG = 11;
  localparam int unsigned BIT_SENSOR = 12;
  localparam logic [15:0] BIT_RESET = 16'h0000;

  // ---------------------------------------------------------------------------
  // Estimator gain states
  // ---------------------------------------------------------------------------
  typedef enum logic [2:0] {
    ST_INIT = 3'b000,
    ST_HIGH = 3'b001,
    ST_NORMAL = 3'b010,
    ST_FREE = 3'b011,
    ST_FAULT = 3'b100
  } agms_state_t;

endpackage

`default_nettype wire

/* logic/agms_axis_check.sv */
// Per-axis rate magnitude checks for the gain mode supervisor.
// Assumes all rate inputs come from logic on the same clock.
`timescale 1ns/1ns
`default_nettype none

module agms_axis_check (
  input wire logic [47:0] rate,
  input wire logic [47:0] lp_rate,
  input wire logic [15:0] turn_limit,
  output logic over_any,
  output logic quiet_all,
  output logic turn_exceeded
);

  logic [2:0] over;
  logic [2:0] quiet;
  logic [16:0] yaw_mag;

  // ---------------------------------------------------------------------------
  // Magnitudes per axis
  // ---------------------------------------------------------------------------
  // Magnitudes use 17 bits so that the most negative code does not wrap.
  genvar i;
  generate
    for (i = 0; i < 3; i++) begin : g_axis
      logic [15:0] raw;
      logic [15:0] lp;
      logic [16:0] raw_mag;
      logic [16:0] lp_mag;
      assign raw = rate[16*i +: 16];
      assign lp = lp_rate[16*i +: 16];
      assign raw_mag = raw[15] ? (17'h00000 - {raw[15], raw}) : {1'b0, raw};
      assign lp_mag = lp[15] ? (17'h00000 - {lp[15], lp}) : {1'b0, lp};
      assign over[i] = raw_mag > agms_pkg::RATE_MAX_LIM;
      assign quiet[i] = lp_mag < agms_pkg::QUIET_LIM;
    end
  endgenerate

  // Axis 2 is yaw; the turn test looks at its filtered magnitude.
  assign yaw_mag = g_axis[2].lp_mag;
  assign over_any = |over;
  assign quiet_all = &quiet;
  assign turn_exceeded = yaw_mag > {1'b0, turn_limit};

endmodule

`default_nettype wire

/* logic/agms_supervisor.sv */
// Attitude estimator gain mode supervisor with an AHB-Lite register slave.
// Assumes rate inputs are on clk; the estimator obeys the gain and mode outputs.
`timescale 1ns/1ns
`default_nettype none

module agms_supervisor #(
  parameter int unsigned UPDATE_DIV = agms_pkg::UPDATE_DIV,
  parameter int unsigned FREE_LIMIT = agms_pkg::FREE_LIMIT_UPD,
  parameter int unsigned INIT_UPD = agms_pkg::INIT_UPD,
  parameter int unsigned HIGH_UPD = agms_pkg::HIGH_UPD
) (
  input wire logic clk,
  input wire logic nrst,
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic [31:0] hrdata,
  output logic hreadyout,
  output logic hresp,
  input wire logic [15:0] rate_x,
  input wire logic [15:0] rate_y,
  input wire logic [15:0] rate_z,
  input wire logic [15:0] lp_rate_x,
  input wire logic [15:0] lp_rate_y,
  input wire logic [15:0] lp_rate_z,
  output logic update_tick,
  output logic [2:0] gain_state,
  output logic estimator_reset,
  output logic free_gyro_active,
  output logic filter_corrections_on,
  output logic accel_coupling_on,
  output logic heavy_accel_feedback,
  output logic accel_feedback_reduced,
  output logic fatal_fault_flag,
  output logic rate_range_exceeded,
  output logic [15:0] bit_word
);

  agms_pkg::agms_state_t state;
  agms_pkg::agms_state_t next_state;
  logic next_reset;
  logic [16:0] div_cnt;
  logic [15:0] phase_cnt;
  logic [15:0] free_timer;
  logic free_en;
  logic restart_after_range_fault;
  logic dynamic_motion;
  logic [15:0] turn_limit;
  logic over_any;
  logic quiet_all;
  logic turn_exceeded;
  logic addr_ok;
  logic wr_pend;
  logic [7:0] wr_addr;
  logic [31:0] next_rdata;
  logic init_done;
  logic high_done;
  logic long_stay;

  // ---------------------------------------------------------------------------
  // Estimator update divider
  // ---------------------------------------------------------------------------
  // One-cycle enable at the estimator update rate; all mode decisions use it.
  always_ff @(posedge clk) begin
    if (!nrst) begin
      div_cnt <= 17'h00000;
      update_tick <= 1'b0;
    end else if (div_cnt == 17'(UPDATE_DIV - 1)) begin
      div_cnt <= 17'h00000;
      update_tick <= 1'b1;
    end else begin
      div_cnt <= div_cnt + 17'h00001;
      update_tick <= 1'b0;
    end
  end

  // ---------------------------------------------------------------------------
  // Rate checks
  // ---------------------------------------------------------------------------
  agms_axis_check u_check (
    .rate({rate_z, rate_y, rate_x}),
    .lp_rate({lp_rate_z, lp_rate_y, lp_rate_x}),
    .turn_limit(turn_limit),
    .over_any(over_any),
    .quiet_all(quiet_all),
    .turn_exceeded(turn_exceeded)
  );

  // ---------------------------------------------------------------------------
  // Mode state machine
  // ---------------------------------------------------------------------------
  assign init_done = phase_cnt >= 16'(INIT_UPD - 1);
  assign high_done = phase_cnt >= 16'(HIGH_UPD - 1);
  // Exactly sixty seconds counts as a short stay; only a longer one resets.
  assign long_stay = free_timer > 16'(FREE_LIMIT);

  // Over-range with restart on pre-empts every other transition outside the fault state.
  always_comb begin
    next_state = state;
    next_reset = 1'b0;
    if (state != agms_pkg::ST_FAULT && restart_after_range_fault && over_any) begin
      next_state = agms_pkg::ST_FAULT;
    end else begin
      unique case (state)
        agms_pkg::ST_INIT: begin
          if (free_en) begin
            next_state = agms_pkg::ST_FREE;
          end else if (init_done) begin
            next_state = agms_pkg::ST_HIGH;
          end
        end
        agms_pkg::ST_HIGH: begin
          if (free_en) begin
            next_state = agms_pkg::ST_FREE;
          end else if (high_done) begin
            next_state = agms_pkg::ST_NORMAL;
          end
        end
        agms_pkg::ST_NORMAL: begin
          if (free_en) begin
            next_state = agms_pkg::ST_FREE;
          end
        end
        agms_pkg::ST_FREE: begin
          if (!free_en && long_stay) begin
            next_state = agms_pkg::ST_INIT;
            next_reset = 1'b1;
          end else if (!free_en) begin
            next_state = agms_pkg::ST_NORMAL;
          end
        end
        agms_pkg::ST_FAULT: begin
          if (quiet_all) begin
            next_state = agms_pkg::ST_INIT;
            next_reset = 1'b1;
          end
        end
        default: begin
          next_state = agms_pkg::ST_INIT;
          next_reset = 1'b1;
        end
      endcase
    end
  end

  // State and the estimator reset pulse move only on update ticks.
  always_ff @(posedge clk) begin
    if (!nrst) begin
      state <= agms_pkg::ST_INIT;
      estimator_reset <= 1'b0;
    end else begin
      estimator_reset <= update_tick && next_reset;
      if (update_tick) begin
        state <= next_state;
      end
    end
  end

  // Time spent in the current state, used for the initialisation phases.
  always_ff @(posedge clk) begin
    if (!nrst) begin
      phase_cnt <= 16'h0000;
    end else if (update_tick) begin
      if (next_state != state) begin
        phase_cnt <= 16'h0000;
      end else if (phase_cnt != 16'hffff) begin
        phase_cnt <= phase_cnt + 16'h0001;
      end
    end
  end

  // Free-gyro duration; saturates so a very long stay still reads as long.
  always_ff @(posedge clk) begin
    if (!nrst) begin
      free_timer <= 16'h0000;
    end else if (update_tick) begin
      if (state != agms_pkg::ST_FREE) begin
        free_timer <= 16'h0000;
      end else if (free_timer != 16'hffff) begin
        free_timer <= free_timer + 16'h0001;
      end
    end
  end

  // ---------------------------------------------------------------------------
  // Estimator controls and status
  // ---------------------------------------------------------------------------
  assign gain_state = state;
  assign free_gyro_active = state == agms_pkg::ST_FREE;
  assign filter_corrections_on = !free_gyro_active;
  assign accel_coupling_on = !free_gyro_active;
  assign heavy_accel_feedback = state == agms_pkg::ST_INIT || state == agms_pkg::ST_HIGH
                                || !dynamic_motion;
  assign accel_feedback_reduced = turn_exceeded && !free_gyro_active;
  assign fatal_fault_flag = state == agms_pkg::ST_FAULT;

  // Over-range status follows the condition, sampled each update.
  always_ff @(posedge clk) begin
    if (!nrst) begin
      rate_range_exceeded <= 1'b0;
    end else if (update_tick) begin
      rate_range_exceeded <= over_any;
    end
  end

  // The test word lags the mode by one cycle; unrelated bits read zero.
  always_ff @(posedge clk) begin
    if (!nrst) begin
      bit_word <= agms_pkg::BIT_RESET;
    end else begin
      bit_word <= agms_pkg::BIT_RESET;
      bit_word[agms_pkg::BIT_FATAL] <= fatal_fault_flag;
      bit_word[agms_pkg::BIT_ALG] <= state == agms_pkg::ST_INIT
                                     || state == agms_pkg::ST_HIGH;
      bit_word[agms_pkg::BIT_SENSOR] <= rate_range_exceeded;
    end
  end

  // ---------------------------------------------------------------------------
  // AHB-Lite slave
  // ---------------------------------------------------------------------------
  // Zero wait states and always OKAY; unmapped reads return zero.
  assign hreadyout = 1'b1;
  assign hresp = 1'b0;
  assign addr_ok = hsel && hready && htrans[1];

  always_ff @(posedge clk) begin
    if (!nrst) begin
      wr_pend <= 1'b0;
      wr_addr <= 8'h00;
    end else begin
      wr_pend <= addr_ok && hwrite && haddr[31:8] == 24'h000000;
      wr_addr <= haddr[7:0];
    end
  end

  // Write data arrives one cycle after its address phase.
  always_ff @(posedge clk) begin
    if (!nrst) begin
      free_en <= agms_pkg::CTRL_FREE_RESET;
      restart_after_range_fault <= agms_pkg::CTRL_RESTART_RESET;
      dynamic_motion <= agms_pkg::CTRL_DYN_RESET;
      turn_limit <= agms_pkg::TURN_RESET;
    end else if (wr_pend) begin
      if (wr_addr == agms_pkg::CTRL_OFS) begin
        free_en <= hwdata[agms_pkg::CTRL_FREE_BIT];
        restart_after_range_fault <= hwdata[agms_pkg::CTRL_RESTART_BIT];
        dynamic_motion <= hwdata[agms_pkg::CTRL_DYN_BIT];
      end else if (wr_addr == agms_pkg::TURN_OFS) begin
        turn_limit <= hwdata[15:0];
      end
    end
  end

  always_comb begin
    next_rdata = 32'h00000000;
    if (haddr[31:8] == 24'h000000) begin
      if (haddr[7:0] == agms_pkg::CTRL_OFS) begin
        next_rdata[agms_pkg::CTRL_FREE_BIT] = free_en;
        next_rdata[agms_pkg::CTRL_RESTART_BIT] = restart_after_range_fault;
        next_rdata[agms_pkg::CTRL_DYN_BIT] = dynamic_motion;
      end else if (haddr[7:0] == agms_pkg::TURN_OFS) begin
        next_rdata[15:0] = turn_limit;
      end else if (haddr[7:0] == agms_pkg::STAT_OFS) begin
        next_rdata[15:0] = bit_word;
        next_rdata[agms_pkg::STAT_STATE_LSB +: 3] = state;
      end else if (haddr[7:0] == agms_pkg::TIMER_OFS) begin
        next_rdata[15:0] = free_timer;
      end
    end
  end

  // Read data is captured in the address phase and stands in the data phase.
  always_ff @(posedge clk) begin
    if (!nrst) begin
      hrdata <= 32'h00000000;
    end else if (addr_ok && !hwrite) begin
      hrdata <= next_rdata;
    end
  end

  // ---------------------------------------------------------------------------
  // Assertions
  // ---------------------------------------------------------------------------
  default clocking cb @(posedge clk); endclocking
  default disable iff (!nrst);

  sequence reset_into_init;
    estimator_reset && state == agms_pkg::ST_INIT ##1 !estimator_reset;
  endsequence

  sequence free_exit;
    update_tick && state == agms_pkg::ST_FREE && !free_en
    && !(restart_after_range_fault && over_any);
  endsequence

  free_entry_a: assert property ($rose(free_gyro_active) |-> $past(free_en))
    else $error("free-gyro mode entered while disabled");
  short_exit_a: assert property (free_exit and !long_stay
    |=> state == agms_pkg::ST_NORMAL && !estimator_reset)
    else $error("short free-gyro stay did not resume normal gain");
  long_exit_a: assert property (free_exit and long_stay |=> reset_into_init)
    else $error("long free-gyro stay did not reset estimator");
  range_flag_a: assert property (update_tick && over_any
    |=> rate_range_exceeded ##1 bit_word[agms_pkg::BIT_SENSOR])
    else $error("over-range not shown in status");
  fatal_entry_a: assert property (update_tick && restart_after_range_fault && over_any
    |=> fatal_fault_flag ##1 bit_word[agms_pkg::BIT_FATAL])
    else $error("fatal flag not raised on over-range");
  fatal_hold_a: assert property (fatal_fault_flag && !(update_tick && quiet_all)
    |=> fatal_fault_flag)
    else $error("fatal flag dropped before quiet condition");
  quiet_restart_a: assert property (update_tick && fatal_fault_flag && quiet_all
    |=> reset_into_init)
    else $error("quiet condition did not restart estimator");
  high_gain_a: assert property (estimator_reset |-> heavy_accel_feedback
    ##1 bit_word[agms_pkg::BIT_ALG])
    else $error("reset did not enter high gain");
  dyn_gain_a: assert property ($fell(dynamic_motion) |-> heavy_accel_feedback)
    else $error("dynamic motion off without heavy feedback");
  // The yaw magnitude is rebuilt here from the pin so a broken axis check cannot hide.
  turn_gain_a: assert property ((lp_rate_z[15] ? 16'h0000 - lp_rate_z : lp_rate_z)
    > turn_limit && !free_gyro_active |-> accel_feedback_reduced)
    else $error("turn did not reduce accelerometer gain");
  timer_step_a: assert property (update_tick && state == agms_pkg::ST_FREE
    && free_timer != 16'hffff |=> free_timer == $past(free_timer) + 16'h0001)
    else $error("free-gyro timer did not advance");

endmodule

`default_nettype wire

/* tb/agms_host.sv */
// Host-side bus master model for the gain mode supervisor.
// Assumes one AHB-Lite slave whose hreadyout is looped back as hready.
`timescale 1ns/1ns
`default_nettype none

module agms_host (
  input wire logic clk,
  input wire logic hready,
  input wire logic [31:0] hrdata,
  output logic hsel,
  output logic [31:0] haddr,
  output logic [1:0] htrans,
  output logic hwrite,
  output logic [2:0] hsize,
  output logic [31:0] hwdata
);
  // ---------------------------------------------------------------------------
  // Bus transfers
  // ---------------------------------------------------------------------------
  // The bus is idle from time zero.
  initial begin
    hsel = 1'b0;
    haddr = 32'h00000000;
    htrans = 2'b00;
    hwrite = 1'b0;
    hsize = 3'b010;
    hwdata = 32'h00000000;
  end

  // One single word transfer; the master never assumes a wait count, it polls hready.
  // Write data is inverted afterwards so stale data never passes for a live value.
  task automatic xfer(input logic w, input logic [7:0] a, input logic [31:0] wd,
                      output logic [31:0] rd);
    @(posedge clk);
    hsel <= 1'b1;
    haddr <= {24'h000000, a};
    htrans <= 2'b10;
    hwrite <= w;
    hsize <= 3'b010;
    do @(posedge clk); while (hready !== 1'b1);
    hsel <= 1'b0;
    htrans <= 2'b00;
    hwdata <= wd;
    do @(posedge clk); while (hready !== 1'b1);
    rd = hrdata;
    hwdata <= ~wd;
  endtask
endmodule

`default_nettype wire

/* tb/test_agms_supervisor.sv */
// Self-checking testbench for the attitude gain mode supervisor.
// Assumes the shortened counts below and the host model as bus master.
`timescale 1ns/1ns
`default_nettype none

`define CHK(nm, exp, got) \
  begin \
    n_checks++; \
    if ((got) !== (exp)) begin \
      errors++; \
      $display("BAD %s expected %h seen %h", nm, (exp), (got)); \
    end \
  end

module test_agms_supervisor;
  logic clk, nrst, hsel, hwrite, hreadyout, hresp, update_tick, estimator_reset;
  logic free_gyro_active, filter_corrections_on, accel_coupling_on, heavy_accel_feedback;
  logic accel_feedback_reduced, fatal_fault_flag, rate_range_exceeded;
  logic [1:0] htrans;
  logic [2:0] hsize, gain_state;
  logic [31:0] haddr, hwdata, hrdata, rv;
  logic [15:0] rate_x, rate_y, rate_z, lp_rate_x, lp_rate_y, lp_rate_z, bit_word;
  int errors, n_checks, n_rst, rst0;
  localparam logic [15:0] OV = 16'h4b01;

  agms_host host (.clk(clk), .hready(hreadyout), .hrdata(hrdata), .hsel(hsel),
    .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata));

  agms_supervisor #(.UPDATE_DIV(4), .FREE_LIMIT(10), .INIT_UPD(2), .HIGH_UPD(3)) dut (
    .clk(clk), .nrst(nrst), .hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite),
    .hsize(hsize), .hwdata(hwdata), .hready(hreadyout), .hrdata(hrdata),
    .hreadyout(hreadyout), .hresp(hresp), .rate_x(rate_x), .rate_y(rate_y),
    .rate_z(rate_z), .lp_rate_x(lp_rate_x), .lp_rate_y(lp_rate_y), .lp_rate_z(lp_rate_z),
    .update_tick(update_tick), .gain_state(gain_state), .estimator_reset(estimator_reset),
    .free_gyro_active(free_gyro_active), .filter_corrections_on(filter_corrections_on),
    .accel_coupling_on(accel_coupling_on), .heavy_accel_feedback(heavy_accel_feedback),
    .accel_feedback_reduced(accel_feedback_reduced), .fatal_fault_flag(fatal_fault_flag),
    .rate_range_exceeded(rate_range_exceeded), .bit_word(bit_word));

  // ---------------------------------------------------------------------------
  // Clock, monitors and tasks
  // ---------------------------------------------------------------------------
  // A 50 ns period gives the 20 MHz system clock.
  always #25 clk = ~clk;

  // Reset pulses are counted on the falling edge, away from the launching edge.
  always @(negedge clk) begin
    if (estimator_reset === 1'b1) n_rst++;
  end

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic [31:0] t;
    host.xfer(1'b1, a, d, t);
  endtask

  task automatic chk_rd(input string nm, input logic [7:0] a, input logic [31:0] e);
    host.xfer(1'b0, a, 32'h00000000, rv);
    `CHK(nm, e, rv);
  endtask

  // Waits for n estimator updates, then lets the state, reset pulse and status word land.
  task automatic wait_ticks(input int n);
    repeat (n) begin
      do @(negedge clk); while (update_tick !== 1'b1);
    end
    repeat (3) @(negedge clk);
  endtask

  task automatic rates(input logic [15:0] x, y, z, lx, ly, lz);
    @(posedge clk);
    rate_x <= x;
    rate_y <= y;
    rate_z <= z;
    lp_rate_x <= lx;
    lp_rate_y <= ly;
    lp_rate_z <= lz;
  endtask

  task automatic turn_case(input logic [15:0] lim, input logic [15:0] lz, input logic e);
    wr(agms_pkg::TURN_OFS, {16'h0000, lim});
    rates(16'h0000, 16'h0000, 16'h0000, 16'h0000, 16'h0000, lz);
    @(negedge clk);
    `CHK("turn reduce", e, accel_feedback_reduced);
  endtask

  task automatic results;
    $display("checks %0d errors %0d", n_checks, errors);
    if (errors == 0 && n_checks > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask

  // The tests need a few hundred clocks; 5000 leaves a wide margin before a hang is cut.
  initial begin
    #250000;
    errors++;
    results();
  end

  // ---------------------------------------------------------------------------
  // Test sequence
  // ---------------------------------------------------------------------------
  // Mode scenarios in order: defaults, turn, dynamic, free gyro, over-range, restart.
  initial begin
    clk = 1'b0;
    nrst = 1'b0;
    {rate_x, rate_y, rate_z, lp_rate_x, lp_rate_y, lp_rate_z} = '0;
    repeat (12) @(posedge clk);
    nrst <= 1'b1;
    chk_rd("ctrl", agms_pkg::CTRL_OFS, 32'h00000004);
    chk_rd("turn", agms_pkg::TURN_OFS, 32'h00000280);
    chk_rd("unmapped", 8'h40, 32'h00000000);
    `CHK("hresp", 1'b0, hresp);
    wait_ticks(1);
    `CHK("init status", 1'b1, bit_word[11]);
    `CHK("init heavy", 1'b1, heavy_accel_feedback);
    wait_ticks(8);
    `CHK("normal", 3'(agms_pkg::ST_NORMAL), gain_state);
    `CHK("normal word", 16'h0000, bit_word);
    `CHK("normal heavy", 1'b0, heavy_accel_feedback);
    turn_case(16'h0280, 16'h0281, 1'b1);
    turn_case(16'h0280, 16'h0280, 1'b0);
    turn_case(16'h0280, 16'hfd7f, 1'b1);
    turn_case(16'h0100, 16'h0101, 1'b1);
    turn_case(16'h0280, 16'h0000, 1'b0);
    wr(agms_pkg::CTRL_OFS, 32'h00000000);
    wait_ticks(2);
    `CHK("dyn off heavy", 1'b1, heavy_accel_feedback);
    wr(agms_pkg::CTRL_OFS, 32'h00000004);
    wait_ticks(2);
    `CHK("dyn on heavy", 1'b0, heavy_accel_feedback);
    // Free gyro is only asked for once initialisation has finished.
    rst0 = n_rst;
    wr(agms_pkg::CTRL_OFS, 32'h00000005);
    rates(16'h0000, 16'h0000, 16'h0000, 16'h0000, 16'h0000, 16'h0400);
    wait_ticks(2);
    `CHK("free state", 3'(agms_pkg::ST_FREE), gain_state);
    `CHK("free flags", 4'b1000, {free_gyro_active, filter_corrections_on,
      accel_coupling_on, accel_feedback_reduced});
    wait_ticks(12);
    wr(agms_pkg::CTRL_OFS, 32'h00000004);
    wait_ticks(1);
    `CHK("long exit reset", rst0 + 1, n_rst);
    `CHK("long exit status", 1'b1, bit_word[11]);
    wait_ticks(8);
    rst0 = n_rst;
    wr(agms_pkg::CTRL_OFS, 32'h00000005);
    wait_ticks(3);
    host.xfer(1'b0, agms_pkg::TIMER_OFS, 32'h00000000, rv);
    `CHK("timer cleared", 1'b1, rv[15:0] < 16'h000a);
    wr(agms_pkg::CTRL_OFS, 32'h00000004);
    wait_ticks(2);
    `CHK("short exit", 3'(agms_pkg::ST_NORMAL), gain_state);
    `CHK("short no reset", rst0, n_rst);
    // Restart stays off while each over-range is brief.
    for (int i = 0; i < 3; i++) begin
      rates(i == 0 ? OV : 16'h0000, i == 1 ? OV : 16'h0000, i == 2 ? OV : 16'h0000,
        16'h0000, 16'h0000, 16'h0000);
      wait_ticks(1);
      `CHK("over flag", 1'b1, rate_range_exceeded);
      `CHK("over word", 2'b10, {bit_word[12], bit_word[0]});
    end
    rates(16'h4b00, 16'h0000, 16'h0000, 16'h0000, 16'h0000, 16'h0000);
    wait_ticks(1);
    `CHK("edge range", 1'b0, rate_range_exceeded);
    rates(16'hb4ff, 16'h0000, 16'h0000, 16'h0000, 16'h0000, 16'h0000);
    wait_ticks(1);
    `CHK("neg range", 1'b1, rate_range_exceeded);
    `CHK("over no reset", 3'(agms_pkg::ST_NORMAL), gain_state);
    `CHK("over reset count", rst0, n_rst);
    wr(agms_pkg::CTRL_OFS, 32'h00000006);
    rates(16'h0000, 16'h0000, OV, 16'h00c0, 16'h0000, 16'h0000);
    wait_ticks(1);
    `CHK("fatal set", 1'b1, fatal_fault_flag);
    chk_rd("stat", agms_pkg::STAT_OFS, 32'h00041001);
    rates(16'h0000, 16'h0000, 16'h0000, 16'h00c0, 16'h0000, 16'h0000);
    wait_ticks(3);
    `CHK("fatal held", 1'b1, fatal_fault_flag);
    rates(16'h0000, 16'h0000, 16'h0000, 16'h00bf, 16'hff41, 16'h0000);
    wait_ticks(1);
    `CHK("fatal clear", 2'b00, {fatal_fault_flag, bit_word[0]});
    `CHK("quiet reset", rst0 + 1, n_rst);
    `CHK("quiet status", 1'b1, bit_word[11]);
    wait_ticks(8);
    `CHK("restart normal", 3'(agms_pkg::ST_NORMAL), gain_state);
    results();
  end
endmodule

`default_nettype wire
